/* File: design/qcs_clock_network.sv */
// Operation
// R1: every quadrant carries eight primary clock lines, numbered 0 to 7.
// R2: centre multiplexers, identical per quadrant, drive lines and see every source.
// R3: any one source may be picked onto lines of all quadrants together.
// R4: switch changes between two unrelated clocks without glitch or runt pulse.
// R5: two switches in each quadrant, eight across the device.
// R6: switch inputs come from centre muxes; outputs drive lines 6 and 7.
// R7: switch has a default mode and configurable alternative modes.
// R8: sync select, gate old clock while low, start new clock while low.
`timescale 1ns/1ps
module qcs_clock_network #(
  parameter int NUM_SOURCES = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // raw clock sources, asynchronous to ref_clk
  input wire logic [NUM_SOURCES-1:0] clock_source,
  // static configuration, one record per quadrant
  input wire qcs_pkg::qcs_quad_cfg_s [qcs_pkg::NUM_QUADRANTS-1:0] quad_cfg,
  // user select per switch, asynchronous, 0 picks input a
  input wire logic [qcs_pkg::NUM_QUADRANTS-1:0]
    [qcs_pkg::SWITCHES_PER_QUADRANT-1:0] switch_select,
  // primary clock lines per quadrant
  output logic [qcs_pkg::NUM_QUADRANTS-1:0]
    [qcs_pkg::LINES_PER_QUADRANT-1:0] primary_clock_line
);

  // an index must reach every source and at least two must exist
  if (NUM_SOURCES < 2 || NUM_SOURCES > (1 << qcs_pkg::SRC_W)) begin : g_chk
    $error("NUM_SOURCES out of range for the source index width");
  end

  // switch lines must sit just above the plain lines, or two drivers meet or a line is left undriven
  if (qcs_pkg::MUX_LINES != qcs_pkg::SWITCH_LINE_BASE) begin : g_chk_base
    $error("plain lines and switch lines overlap or leave a gap");
  end

  // plain lines plus switch lines fill the quadrant exactly
  if (qcs_pkg::SWITCH_LINE_BASE + qcs_pkg::SWITCHES_PER_QUADRANT !=
      qcs_pkg::LINES_PER_QUADRANT) begin : g_chk_fill // R1
    $error("switch lines do not end on the last primary line");
  end

  // the select chain below is written out for exactly two stages
  if (qcs_pkg::SYNC_STAGES != 2) begin : g_chk_sync // R8
    $error("select synchroniser depth is fixed at two");
  end

  // a line that woke high would show a false edge as reset lifts
  if (qcs_pkg::LINE_RESET != 1'h0) begin : g_chk_rst
    $error("primary lines must reset low");
  end

  // a switch must wake gated, so its first clock is joined while low
  if (qcs_pkg::STATE_RESET != qcs_pkg::ST_GATED) begin : g_chk_wake // R8
    $error("switch must leave reset in the gated state");
  end

  // centre mux pick; an index past the last source reads as a quiet line
  function automatic logic pick_source(
    input logic [NUM_SOURCES-1:0] vec,
    input logic [qcs_pkg::SRC_W-1:0] idx
  );
    logic bit_out;
    bit_out = 1'b0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (idx == i[qcs_pkg::SRC_W-1:0]) begin
        bit_out = vec[i];
      end
    end
    return bit_out;
  endfunction

  // switch output for the state being entered; the gated state stays
  // quiet, so a change of input never shows a partial high
  function automatic logic switch_out(
    input qcs_pkg::qcs_state_e st,
    input logic a,
    input logic b
  );
    logic v;
    unique case (st)
      qcs_pkg::ST_RUN_A: v = a;
      qcs_pkg::ST_RUN_B: v = b;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // two-stage synchroniser on all sources, shared by every quadrant
  logic [NUM_SOURCES-1:0] src_meta_reg;
  logic [NUM_SOURCES-1:0] src_sync_reg;
  logic [NUM_SOURCES-1:0] src_meta_next;
  logic [NUM_SOURCES-1:0] src_sync_next;

  always_comb begin
    src_meta_next = clock_source;
    src_sync_next = src_meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end else begin
      src_meta_reg <= src_meta_next;
      src_sync_reg <= src_sync_next;
    end
  end

  // one identical centre mux bank per quadrant
  for (genvar q = 0; q < qcs_pkg::NUM_QUADRANTS; q++) begin : g_quad // R2

    // plain lines 0..5, each free to take any source, so one source can
    // be chosen on every quadrant at once
    logic [qcs_pkg::MUX_LINES-1:0] line_reg;
    logic [qcs_pkg::MUX_LINES-1:0] line_next;

    // each plain line samples its chosen source
    always_comb begin
      for (int l = 0; l < qcs_pkg::MUX_LINES; l++) begin
        line_next[l] = pick_source(src_sync_reg,
                                   quad_cfg[q].line_src[l]); // R3
      end
    end

    // register the plain lines so every output leaves a flop
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        line_reg <= {qcs_pkg::MUX_LINES{qcs_pkg::LINE_RESET}};
      end else begin
        line_reg <= line_next;
      end
    end

    // plain lines straight onto the output
    for (genvar l = 0; l < qcs_pkg::MUX_LINES; l++) begin : g_line
      assign primary_clock_line[q][l] = line_reg[l]; // R1
    end

    // two glitchless clock switches per quadrant
    for (genvar s = 0; s < qcs_pkg::SWITCHES_PER_QUADRANT; s++) begin : g_sw
      // R5

      logic [1:0] sel_sync_reg; // [0] first stage, [1] second stage
      logic [1:0] sel_sync_next;
      qcs_pkg::qcs_state_e state_reg;
      qcs_pkg::qcs_state_e state_next;
      logic out_reg;
      logic out_next;
      logic clk_a;
      logic clk_b;
      logic want_b;

      // both switch inputs are centre mux outputs
      assign clk_a = pick_source(src_sync_reg, quad_cfg[q].sw[s].src_a); // R6
      assign clk_b = pick_source(src_sync_reg, quad_cfg[q].sw[s].src_b); // R6

      // select synchroniser; only the second stage feeds the sequencer
      always_comb begin
        sel_sync_next = {sel_sync_reg[0], switch_select[q][s]}; // R8
      end

      // mode decides whether the user select is obeyed at all
      always_comb begin
        unique case (quad_cfg[q].sw[s].mode) // R7
          qcs_pkg::MODE_DEFAULT: want_b = sel_sync_reg[1];
          qcs_pkg::MODE_HOLD_A: want_b = 1'b0;
          qcs_pkg::MODE_HOLD_B: want_b = 1'b1;
          default: want_b = sel_sync_reg[1]; // unused code acts as default
        endcase
      end

      // leave a clock only while it is low, join the next only while it
      // is low, so no edge is cut short; costs a few idle-low cycles
      always_comb begin
        state_next = state_reg;
        unique case (state_reg)
          qcs_pkg::ST_RUN_A: begin
            if (want_b && !clk_a) begin
              state_next = qcs_pkg::ST_GATED; // R8
            end
          end
          qcs_pkg::ST_RUN_B: begin
            if (!want_b && !clk_b) begin
              state_next = qcs_pkg::ST_GATED; // R8
            end
          end
          qcs_pkg::ST_GATED: begin
            if (want_b && !clk_b) begin
              state_next = qcs_pkg::ST_RUN_B; // R8
            end else if (!want_b && !clk_a) begin
              state_next = qcs_pkg::ST_RUN_A; // R8
            end
          end
          default: state_next = qcs_pkg::ST_GATED;
        endcase
        // output follows the clock of the state being entered
        out_next = switch_out(state_next, clk_a, clk_b); // R4
      end

      // select chain, sequencer state and output flop of one switch
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          sel_sync_reg <= qcs_pkg::SYNC_RESET;
          state_reg <= qcs_pkg::STATE_RESET;
          out_reg <= qcs_pkg::LINE_RESET;
        end else begin
          sel_sync_reg <= sel_sync_next;
          state_reg <= state_next;
          out_reg <= out_next;
        end
      end

      // switch outputs land on lines 6 and 7
      assign primary_clock_line[q][qcs_pkg::SWITCH_LINE_BASE + s] =
        out_reg; // R6
    end
  end

endmodule

/* File: design/qcs_pkg.sv */
// shared constants and carriers for the quadrant clock network
package qcs_pkg;

  // network shape
  localparam int NUM_QUADRANTS = 4;
  localparam int LINES_PER_QUADRANT = 8;
  localparam int SWITCHES_PER_QUADRANT = 2;
  localparam int MUX_LINES = 6;       // lines 0..5 come straight from centre
  localparam int SWITCH_LINE_BASE = 6; // switch s drives line 6 + s
  localparam int SRC_W = 5;            // width of a centre mux source index
  localparam int SYNC_STAGES = 2;

  // reset values
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic LINE_RESET = 1'h0;

  // switch operating modes set by configuration
  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'h0, // follow the user select
    MODE_HOLD_A = 2'h1,  // ignore select, stay on input a
    MODE_HOLD_B = 2'h2   // ignore select, stay on input b
  } qcs_mode_e;

  // switch sequencing states
  typedef enum logic [1:0] {
    ST_RUN_A = 2'h0,
    ST_GATED = 2'h1,
    ST_RUN_B = 2'h2
  } qcs_state_e;

  localparam qcs_state_e STATE_RESET = ST_GATED;

  // configuration of one glitchless switch
  typedef struct packed {
    logic [SRC_W-1:0] src_a;
    logic [SRC_W-1:0] src_b;
    qcs_mode_e mode;
  } qcs_switch_cfg_s;

  // configuration of one quadrant
  typedef struct packed {
    logic [MUX_LINES-1:0][SRC_W-1:0] line_src;
    qcs_switch_cfg_s [SWITCHES_PER_QUADRANT-1:0] sw;
  } qcs_quad_cfg_s;

endpackage

/* File: verif/qcs_clock_network_monitor.sv */
`timescale 1ns/1ps
module qcs_clock_network_monitor #(
  parameter int NUM_SOURCES = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // sources, configuration and selects
  input wire logic [NUM_SOURCES-1:0] clock_source,
  input wire qcs_pkg::qcs_quad_cfg_s [3:0] quad_cfg,
  input wire logic [3:0][1:0] switch_select,
  // clock lines
  input wire logic [3:0][7:0] primary_clock_line
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // clean edges since reset, saturating; three refill the line pipeline
  logic [1:0] run_cnt_reg;
  logic [1:0] run_cnt_next;
  always_comb begin
    run_cnt_next = run_cnt_reg;
    if (run_cnt_reg != 2'h3) begin
      run_cnt_next = run_cnt_reg + 2'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      run_cnt_reg <= 2'h0;
    end else begin
      run_cnt_reg <= run_cnt_next;
    end
  end
  wire logic settled = run_cnt_reg == 2'h3;
  wire logic a1 = clock_source[quad_cfg[1].sw[1].src_a];
  // the sources each watched line should carry
  wire logic c0 = clock_source[quad_cfg[0].line_src[0]];
  wire logic a0 = clock_source[quad_cfg[0].sw[0].src_a];
  wire logic b0 = clock_source[quad_cfg[0].sw[0].src_b];
  wire logic b1 = clock_source[quad_cfg[0].sw[1].src_b];
  wire logic b2 = clock_source[quad_cfg[2].sw[1].src_b];
  wire logic [7:0] o = primary_clock_line[0];
  // long enough to outlast the old clock's high phase
  sequence sel_b_held;
    switch_select[0][0] [*8];
  endsequence
  a_reset_clear: assert property (disable iff (1'b0)
    !reset_n |=> primary_clock_line == '0) else $error("line set in reset");
  a_line_follows: assert property (settled |->
    o[0] == $past(c0, 3)) else $error("centre line off its source");
  a_global_route: assert property (quad_cfg[0].line_src[0] ==
    quad_cfg[3].line_src[0] |-> o[0] == primary_clock_line[3][0])
    else $error("quadrants differ on one source");
  a_no_runt: assert property ($rose(o[6]) |=> o[6] [*2])
    else $error("runt pulse on switch line");
  a_sw_source: assert property (settled && o[6] |->
    $past(a0, 3) || $past(b0, 3)) else $error("switch high from no input");
  a_sel_follow: assert property (sel_b_held ##0 o[6] |->
    $past(b0, 3)) else $error("switch not on new clock");
  a_hold_b: assert property (quad_cfg[0].sw[1].mode ==
    qcs_pkg::MODE_HOLD_B && settled && o[7] |-> $past(b1, 3))
    else $error("hold mode left input b");
  a_hold_other_quad: assert property (settled &&
    quad_cfg[2].sw[1].mode == qcs_pkg::MODE_HOLD_B &&
    primary_clock_line[2][7] |-> $past(b2, 3)) else $error("quad 2 switch");
  a_hold_a: assert property (settled &&
    quad_cfg[1].sw[1].mode == qcs_pkg::MODE_HOLD_A &&
    primary_clock_line[1][7] |-> $past(a1, 3)) else $error("hold a left a");
endmodule

/* File: verif/qcs_clock_network_test.sv */
`timescale 1ns/1ps
module qcs_clock_network_test;
  logic ref_clk;
  logic reset_n;
  logic [15:0] clock_source;
  qcs_pkg::qcs_quad_cfg_s [3:0] quad_cfg;
  logic [3:0][1:0] switch_select;
  logic [3:0][7:0] primary_clock_line;
  logic [15:0] hist[$];
  int miscompares;
  int check_count;
  int cyc;
  qcs_clock_network i_qcs_clock_network (.ref_clk(ref_clk),
    .reset_n(reset_n), .clock_source(clock_source), .quad_cfg(quad_cfg),
    .switch_select(switch_select), .primary_clock_line(primary_clock_line));
  qcs_clock_sources_model i_qcs_clock_sources_model (.ref_clk(ref_clk),
    .clock_source(clock_source));
  task automatic stop_test();
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // line must repeat its source three edges late
  task automatic watch(input int q, input int l, input int s, input int n);
    hist = {};
    repeat (n) begin
      @(negedge ref_clk);
      hist.push_front(clock_source);
      if (hist.size() > 2) chk("line", hist[2][s], primary_clock_line[q][l]);
    end
  endtask
  task automatic t_centre();
    watch(0, 0, 0, 30);
    for (int l = 1; l < 5; l++) watch(3, l, l, 16);
    for (int q = 0; q < 4; q++) watch(q, 5, 5, 20);
  endtask
  task automatic t_switch();
    switch_select[0][0] = 1'b1;
    repeat (4) @(negedge ref_clk);
    switch_select[0][0] = 1'b0; // reversal while gated
    repeat (2) @(negedge ref_clk);
    switch_select[0][0] = 1'b1;
    repeat (30) @(negedge ref_clk);
    watch(0, 6, 7, 40);
    switch_select[0][0] = 1'b0;
    repeat (30) @(negedge ref_clk);
    watch(0, 6, 0, 40);
  endtask
  task automatic t_hold();
    switch_select = 8'h0A; // second switch of quadrants 0 and 1 asks b
    watch(0, 7, 9, 40);
    watch(1, 7, 8, 40);
    switch_select = 8'h00;
    watch(0, 7, 9, 40);
    watch(2, 7, 9, 30);
  endtask
  task automatic t_reset();
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("lines in reset", 32'h0, primary_clock_line);
    reset_n = 1'b1;
    @(negedge ref_clk);
    chk("lines on release", 32'h0, primary_clock_line);
    watch(1, 0, 0, 20);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    switch_select = '0;
    for (int q = 0; q < 4; q++) begin
      for (int l = 0; l < 6; l++) quad_cfg[q].line_src[l] = 5'(l);
      quad_cfg[q].sw[0] = '{5'h00, 5'h07, qcs_pkg::MODE_DEFAULT};
      quad_cfg[q].sw[1] = '{5'h08, 5'h09, qcs_pkg::MODE_HOLD_B};
    end
    // quadrant 1 second switch pinned to its input a
    quad_cfg[1].sw[1].mode = qcs_pkg::MODE_HOLD_A;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    t_centre();
    t_switch();
    t_hold();
    t_reset();
    stop_test();
  end
endmodule
bind qcs_clock_network qcs_clock_network_monitor #(
  .NUM_SOURCES(NUM_SOURCES)) i_mon (.ref_clk(ref_clk), .reset_n(reset_n),
  .clock_source(clock_source), .quad_cfg(quad_cfg),
  .switch_select(switch_select), .primary_clock_line(primary_clock_line));

/* File: verif/qcs_clock_sources_model.sv */
`timescale 1ns/1ps
module qcs_clock_sources_model #(
  parameter int NUM_SOURCES = 16
) (
  // system clock
  input wire logic ref_clk,
  // unrelated slow clocks
  output logic [NUM_SOURCES-1:0] clock_source
);
  int cnt[NUM_SOURCES];
  initial clock_source = '0;
  // source i toggles every i+3 cycles; shorter phases could not be resolved
  always @(negedge ref_clk)
    for (int i = 0; i < NUM_SOURCES; i++) begin
      cnt[i] = (cnt[i] + 1) % (i + 3);
      if (cnt[i] == 0) clock_source[i] <= ~clock_source[i];
    end
endmodule
